/* File: core/adc_ctrl_defs.svh */
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// ==========================================================
// Register map (byte addresses)
`define CFG_OFFSET      12'h000
`define STATUS_OFFSET   12'h004
`define CONV_OFFSET     12'h008

// ==========================================================
// Configuration fields
`define CFG_USE_REG_BIT 0
`define CFG_PD_BIT      1
`define CFG_IMPULSE_BIT 2
`define CFG_RESET_VAL   3'h0

// ==========================================================
// Timing
`define CONV_TIME_NS    1000
`define CLK_PERIOD_NS   40
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: core/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_CONVERT = 3'b010,
    ST_ABORT   = 3'b100
  } conv_state_e;
endpackage

/* File: core/adc_power_reference_conversion_ctrl.sv */
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"

// What this block does
// [RULE1] Both reference power-down pins low enable bandgap, buffer and temperature sensor.
// [RULE2] Reference pin high, buffer pin low: bandgap off, buffer stays on.
// [RULE3] Each power-down pin switches off its own block.
// [RULE4] Temperature sensor on only while both power-down pins are low.
// [RULE5] Impulse mode: low-current state from conversion end through acquisition.
// [RULE6] Digital interface stays fully usable during acquisition and low power.
// [RULE7] Power-down pin high puts the converter into power-down.
// [RULE8] Power-down lets a running conversion finish; bus stays active.
// [RULE9] A configuration bit can select power-down instead of the pin.
// [RULE10] With configuration register in use the power-down pin is ignored.
// [RULE11] Falling edge of convert start begins a conversion.
// [RULE12] Running conversion ignores further starts and power-down until done.
// [RULE13] Convert start acts whatever the chip-select and read-enable levels.
// [RULE14] Reset rise aborts conversion; reset fall clears configuration register.
module adc_power_reference_conversion_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_ref_powerdown,
  input  wire logic        ref_buffer_powerdown,
  input  wire logic        power_down_input,
  input  wire logic        convert_start_n,
  input  wire logic        chip_select_n,
  input  wire logic        read_enable_n,
  input  wire logic        device_reset,
  output logic             bandgap_en,
  output logic             buffer_en,
  output logic             temp_sensor_en,
  output logic             busy,
  output logic             conv_done,
  output logic             powered_down,
  output logic             low_current,
  output logic             bus_active
);
  // ==========================================================
  // Reference and sensor enables
  ref_mode_decode u_ref (
    .internal_ref_powerdown (internal_ref_powerdown),
    .ref_buffer_powerdown   (ref_buffer_powerdown),
    .bandgap_en             (bandgap_en),
    .buffer_en              (buffer_en),
    .temp_sensor_en         (temp_sensor_en)
  );

  // ==========================================================
  // Edge detection
  logic cnv_rise;
  logic cnv_fall;
  logic rst_rise;
  logic rst_fall;

  edge_detect #(.IDLE_LEVEL(1'b1)) u_cnv (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (convert_start_n),
    .rise    (cnv_rise),
    .fall    (cnv_fall)
  );

  edge_detect #(.IDLE_LEVEL(1'b0)) u_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (device_reset),
    .rise    (rst_rise),
    .fall    (rst_fall)
  );

  // ==========================================================
  // APB decode
  logic [2:0]  cfg_q;
  logic [2:0]  cfg_d;
  logic [31:0] conv_count_q;
  logic        pd_q;
  conv_state_e state_q;
  conv_state_e state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  wire apb_access = psel & penable;
  wire apb_write  = apb_access & pwrite;
  wire sel_cfg    = paddr == `CFG_OFFSET;
  wire sel_status = paddr == `STATUS_OFFSET;
  wire sel_conv   = paddr == `CONV_OFFSET;
  wire mapped     = sel_cfg | sel_status | sel_conv;

  // Zero-wait slave; bus never stalls, even while powered down
  assign pready  = 1'b1;                                        // RULE6 RULE8
  assign pslverr = apb_access & ~mapped;

  wire use_reg   = cfg_q[`CFG_USE_REG_BIT];
  wire impulse   = cfg_q[`CFG_IMPULSE_BIT];
  // Pin ignored when the register owns power-down
  wire pd_req    = use_reg ? cfg_q[`CFG_PD_BIT] : power_down_input;   // RULE9 RULE10

  wire [31:0] status_word = {25'h0, temp_sensor_en, buffer_en, bandgap_en,
                             low_current, powered_down, conv_done, busy};

  wire [31:0] read_mux = sel_cfg    ? {29'h0, cfg_q} :
                         sel_status ? status_word :
                         sel_conv   ? conv_count_q : 32'h0000_0000;
  wire        rd_setup = psel & ~penable & ~pwrite;

  // Captured in the setup cycle: a flop drives the bus, still with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= read_mux;
    end
  end

  // ==========================================================
  // Configuration register
  always_comb begin
    cfg_d = cfg_q;
    if (apb_write && sel_cfg) begin
      cfg_d = pwdata[2:0];
    end
    if (rst_fall) begin
      cfg_d = `CFG_RESET_VAL;                                   // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 3'h0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // Conversion state machine
  // Chip select and read enable are not looked at
  wire start_ok = cnv_fall & ~device_reset & ~pd_q;   // RULE11 RULE13
  wire last_cyc = cnt_q == 16'(CONV_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        cnt_d = 16'h0000;
        if (start_ok) begin
          state_d = ST_CONVERT;                                 // RULE11
        end
      end
      ST_CONVERT: begin
        // Further starts and power-down ignored here
        cnt_d = cnt_q + 16'h0001;                               // RULE12
        if (rst_rise) begin
          state_d = ST_ABORT;                                   // RULE14
        end else if (last_cyc) begin
          state_d = ST_IDLE;
        end
      end
      ST_ABORT: begin
        cnt_d = 16'h0000;
        if (!device_reset) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  wire finishing = (state_q == ST_CONVERT) & last_cyc & ~rst_rise;

  // ==========================================================
  // Power state, done pulse, counter
  logic pd_d;
  // Power-down waits until no conversion runs
  assign pd_d = (state_q == ST_CONVERT) ? pd_q : pd_req;        // RULE7 RULE8 RULE12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_q         <= 1'b0;
      conv_done    <= 1'b0;
      conv_count_q <= 32'h0000_0000;
    end else begin
      pd_q      <= pd_d;
      conv_done <= finishing;
      if (rst_fall) begin
        conv_count_q <= 32'h0000_0000;
      end else if (finishing) begin
        conv_count_q <= conv_count_q + 32'h0000_0001;
      end
    end
  end

  assign busy         = state_q == ST_CONVERT;
  assign powered_down = pd_q;
  // Low current from conversion end through acquisition
  assign low_current  = pd_q | (impulse & ~busy);               // RULE5
  assign bus_active   = 1'b1;                                   // RULE6 RULE8

  // ==========================================================
  // Checks
  logic [15:0] busy_run_q;

  // Own count of busy cycles, so the length check does not reuse cnt_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_run_q <= 16'h0000;
    end else if (busy) begin
      busy_run_q <= busy_run_q + 16'h0001;
    end else begin
      busy_run_q <= 16'h0000;
    end
  end

  sequence conv_begin_s;
    (state_q == ST_IDLE) && start_ok;
  endsequence

  start_to_busy_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    conv_begin_s |=> busy)
    else $error("Start edge did not begin conversion");

  conv_length_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    $fell(busy) && !$past(rst_rise) |-> busy_run_q == 16'(CONV_CYCLES))
    else $error("Conversion length wrong");

  conv_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    busy |-> busy_run_q < 16'(CONV_CYCLES))
    else $error("Conversion ran too long");

  pd_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    busy && $past(busy) |-> $stable(pd_q))
    else $error("Power-down changed during conversion");

  pd_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    !busy && !use_reg && power_down_input |=> pd_q)
    else $error("Power-down pin not obeyed");

  pd_reg_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    !busy && use_reg |=> pd_q == $past(cfg_q[`CFG_PD_BIT]))
    else $error("Register power-down not obeyed");

  temp_en_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    temp_sensor_en == (bandgap_en && buffer_en))
    else $error("Temperature sensor enable wrong");

  impulse_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    impulse && $fell(busy) |-> low_current)
    else $error("Impulse mode not in low current");

  abort_conv_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    busy && rst_rise |=> !busy)
    else $error("Reset did not abort conversion");

  cfg_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    rst_fall |=> cfg_q == 3'h0)
    else $error("Reset did not clear configuration");

  sequence abort_req_s;
    busy && rst_rise;
  endsequence

  sequence abort_hold_s;
    !busy && !conv_done;
  endsequence

  sequence iface_off_s;
    chip_select_n || read_enable_n;
  endsequence

  sequence iface_on_s;
    !chip_select_n && !read_enable_n;
  endsequence

  abort_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    abort_req_s |=> abort_hold_s)
    else $error("Aborted conversion still reported");

  abort_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    (state_q == ST_ABORT) && device_reset |=> state_q == ST_ABORT)
    else $error("Left abort while reset high");

  count_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    rst_fall |=> conv_count_q == 32'h0000_0000)
    else $error("Reset did not clear conversion count");

  done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    $fell(busy) && !$past(rst_rise) |-> conv_done ##1 !conv_done)
    else $error("Done pulse wrong after conversion");

  pd_refuse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (state_q == ST_IDLE) && pd_q && cnv_fall |=> !busy)
    else $error("Conversion started while powered down");

  rst_refuse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    (state_q == ST_IDLE) && device_reset |=> !busy)
    else $error("Conversion started during reset");

  start_cs_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    conv_begin_s ##0 iface_off_s |=> busy)
    else $error("Start lost with interface deselected");

  start_cs_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    conv_begin_s ##0 iface_on_s |=> busy)
    else $error("Start lost with interface selected");

  cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    psel && penable && pwrite && sel_cfg && !rst_fall |=> cfg_q == $past(pwdata[2:0]))
    else $error("Configuration write lost");

  read_cfg_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    psel && penable && !pwrite && sel_cfg |-> prdata == {29'h0, $past(cfg_q)})
    else $error("Configuration read data wrong");

  pd_low_current_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    powered_down |-> low_current)
    else $error("Powered down without low current");

  convert_full_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    impulse && busy && !pd_q |-> !low_current)
    else $error("Low current during conversion");

  ref_buf_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    internal_ref_powerdown && !ref_buffer_powerdown |-> !bandgap_en && buffer_en)
    else $error("External reference with buffer wrong");

  ref_ext_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    internal_ref_powerdown && ref_buffer_powerdown |-> !bandgap_en && !buffer_en && !temp_sensor_en)
    else $error("Direct external reference wrong");
endmodule
`default_nettype wire

/* File: core/edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_detect #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  logic sig_q;

  // Starts at the pin's idle level, so leaving reset shows no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q <= IDLE_LEVEL;
    end else begin
      sig_q <= sig;
    end
  end

  assign rise = sig & ~sig_q;
  assign fall = ~sig & sig_q;
endmodule
`default_nettype wire

/* File: core/ref_mode_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module ref_mode_decode (
  input  wire logic internal_ref_powerdown,
  input  wire logic ref_buffer_powerdown,
  output logic      bandgap_en,
  output logic      buffer_en,
  output logic      temp_sensor_en
);
  // ==========================================================
  // Reference selection
  assign bandgap_en     = ~internal_ref_powerdown;                            // RULE1 RULE2
  assign buffer_en      = ~ref_buffer_powerdown;                              // RULE3
  assign temp_sensor_en = ~internal_ref_powerdown & ~ref_buffer_powerdown;    // RULE4
endmodule
`default_nettype wire

/* File: test/host_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// Host convert-start driver
module host_pins_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start_req,
  output logic      convert_start_n
);
  logic [1:0] low_q;
  // Two-cycle low pulse, so each request gives one clean falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 2'h0;
    end else if (start_req) begin
      low_q <= 2'h2;
    end else if (low_q != 2'h0) begin
      low_q <= low_q - 2'h1;
    end
  end
  assign convert_start_n = (low_q == 2'h0);
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Long enough that an abort is seen well before a normal end
  localparam int CC = 8;
  logic        pclk, presetn, psel, penable, pwrite, start_req, cs_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, ref_pd, buf_pd, pd_pin, cs_n, rd_n, dev_rst;
  logic        bg_en, bf_en, ts_en, busy, conv_done, powered_down, low_current, bus_active;
  int          n_fail, n_compared, n;

  // ====================
  // Design and host
  adc_power_reference_conversion_ctrl #(.CONV_CYCLES(CC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_ref_powerdown(ref_pd), .ref_buffer_powerdown(buf_pd),
    .power_down_input(pd_pin), .convert_start_n(cs_pin), .chip_select_n(cs_n),
    .read_enable_n(rd_n), .device_reset(dev_rst), .bandgap_en(bg_en), .buffer_en(bf_en),
    .temp_sensor_en(ts_en), .busy(busy), .conv_done(conv_done),
    .powered_down(powered_down), .low_current(low_current), .bus_active(bus_active));
  host_pins_model u_host (.pclk(pclk), .presetn(presetn), .start_req(start_req),
    .convert_start_n(cs_pin));

  always begin
    #20 pclk = ~pclk;
  end

  // ====================
  // Tasks
  task tick;
    @(posedge pclk);
    #1;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task start;
    int i;
    @(posedge pclk);
    start_req <= 1'b1;
    @(posedge pclk);
    start_req <= 1'b0;
    i = 0;
    while (busy !== 1'b1 && i < 6) begin
      tick;
      i++;
    end
  endtask

  task conv_end;
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk_word(32'(n), 32'(CC));
    chk_bit(conv_done, 1'b1);
    chk_bit(powered_down, 1'b0);
  endtask

  task wrap_up;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ====================
  // Tests
  initial begin
    {pclk, presetn, psel, penable, pwrite, start_req, ref_pd, buf_pd, pd_pin} = 9'h0;
    {cs_n, rd_n, dev_rst, paddr, pwdata, n_fail, n_compared} = '0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, 32'h0000_0070);
    apb(1'b0, 12'h00C, 32'h0);
    chk_word({err, rd[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      ref_pd <= i[1];
      buf_pd <= i[0];
      tick;
      chk_word({bg_en, bf_en, ts_en}, {~i[1], ~i[0], i == 0});
    end
    @(posedge pclk);
    {ref_pd, buf_pd} <= 2'h0;
    // Chip-select and read-enable stay high for this conversion
    start;
    fork
      conv_end;
      begin
        @(posedge pclk);
        pd_pin <= 1'b1;
        start_req <= 1'b1;
        @(posedge pclk);
        start_req <= 1'b0;
      end
    join
    repeat (2) tick;
    chk_word({bus_active, low_current, powered_down}, 32'h7);
    start;
    chk_bit(busy, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(rd, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h1);
    repeat (2) tick;
    chk_bit(powered_down, 1'b0);
    apb(1'b1, 12'h000, 32'h3);
    repeat (2) tick;
    chk_bit(powered_down, 1'b1);
    apb(1'b1, 12'h000, 32'h5);
    @(posedge pclk);
    pd_pin <= 1'b0;
    {cs_n, rd_n} <= 2'h0;
    repeat (2) tick;
    chk_bit(low_current, 1'b1);
    start;
    chk_bit(low_current, 1'b0);
    conv_end;
    tick;
    chk_bit(low_current, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, 32'h0000_0078);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(rd, 32'h0000_0002);
    start;
    @(posedge pclk);
    dev_rst <= 1'b1;
    repeat (3) tick;
    chk_bit(busy, 1'b0);
    n = 0;
    repeat (12) begin
      tick;
      n += (conv_done === 1'b1);
    end
    chk_word(32'(n), 32'h0);
    @(posedge pclk);
    dev_rst <= 1'b0;
    repeat (2) tick;
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(rd, 32'h0000_0000);
    wrap_up;
  end

  initial begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
